/* hw/range_alarm_defines.svh */
// register offsets, field positions, reset values and reading widths
`ifndef RANGE_ALARM_DEFINES_SVH
`define RANGE_ALARM_DEFINES_SVH

`define RA_OFF_RANGE_CFG 12'h014
`define RA_OFF_ALARM_STAT 12'h020
`define RA_OFF_UPPER_LIM 12'h024
`define RA_OFF_LOWER_LIM 12'h028
`define RA_OFF_IRQ_MASK 12'h030
`define RA_OFF_SUPPLY_LIM 12'h034

`define RA_RANGE_LSB 0
`define RA_RANGE_MSB 3
`define RA_REF_OFF_BIT 6
`define RA_RANGE_RST 4'h0
`define RA_REF_OFF_RST 1'b0

`define RA_LIVE_SUP_LO_BIT 15
`define RA_LIVE_SUP_HI_BIT 14
`define RA_LIVE_IN_LO_BIT 11
`define RA_LIVE_IN_HI_BIT 10
`define RA_LAT_SUP_LO_BIT 7
`define RA_LAT_SUP_HI_BIT 6
`define RA_LAT_IN_LO_BIT 5
`define RA_LAT_IN_HI_BIT 4
`define RA_SUMMARY_BIT 0

`define RA_UPPER_LIM_RST 16'hFFFF
`define RA_LOWER_LIM_RST 16'h0000
`define RA_LIM_PAD 2'h0
`define RA_SAMPLE_W 18
`define RA_SUPPLY_W 12
`define RA_SUP_HI_RST 12'hFFF
`define RA_SUP_LO_RST 12'h000
`define RA_MASK_RST 4'h0

`endif

/* hw/range_alarm_pkg.sv */
// types shared by the range and alarm register bank
package range_alarm_pkg;

  typedef enum logic [3:0] {
    bip_3_0 = 4'h0,
    bip_2_5 = 4'h1,
    bip_1_5 = 4'h2,
    bip_1_25 = 4'h3,
    bip_0_625 = 4'h4,
    uni_3_0 = 4'h8,
    uni_2_5 = 4'h9,
    uni_1_5 = 4'hA,
    uni_1_25 = 4'hB
  } range_code_t;

  typedef struct packed {
    logic supply_low;
    logic supply_high;
    logic input_lowside;
    logic input_highside;
  } alarm_set_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_setup = 3'b010,
    st_access = 3'b100
  } apb_state_t;

endpackage

/* hw/limit_compare.sv */
// one window comparison: live flags above upper or below lower limit
module limit_compare #(
  parameter int W = 18
) (
  // operands
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] upper,
  input wire logic [W-1:0] lower,
  // results
  output logic above,
  output logic below
);
  initial
  begin
    if (W < 2)
    begin
      $error("limit_compare width too small");
    end
  end

  assign above = value > upper;
  assign below = value < lower;
endmodule

/* hw/latched_flag.sv */
// sticky flag: set by event, cleared by a read, set wins over clear
module latched_flag (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic set_evt,
  input wire logic clr,
  // state
  output logic flag_r
);
  logic flag_nxt;

  assign flag_nxt = set_evt ? 1'b1 : (clr ? 1'b0 : flag_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end
endmodule

/* hw/range_alarm_regs.sv */
// range configuration and alarm status register bank on apb
//
// Our own choice: the APB register port.
`include "range_alarm_defines.svh"

module range_alarm_regs #(
  parameter int SAMPLE_W = `RA_SAMPLE_W,
  parameter int SUPPLY_W = `RA_SUPPLY_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion results and supply monitor, same clock
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_code,
  input wire logic supply_valid,
  input wire logic [SUPPLY_W-1:0] supply_code,
  // configuration to the converter
  output logic [3:0] range_code,
  output logic range_unassigned,
  output logic range_unipolar,
  output logic internal_reference_off,
  // interrupt
  output logic alarm_irq
);
  initial
  begin
    if (SAMPLE_W != `RA_SAMPLE_W)
    begin
      $error("sample width must be 18 for padded limits");
    end
    if (SUPPLY_W < 1 || SUPPLY_W > 16)
    begin
      $error("supply width out of range");
    end
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [3:0] range_code_r;
  logic ref_off_r;
  logic [15:0] upper_lim_r;
  logic [15:0] lower_lim_r;
  logic [SUPPLY_W-1:0] sup_hi_r;
  logic [SUPPLY_W-1:0] sup_lo_r;
  logic [3:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  wire access = psel && penable;
  wire wr_en = access && pwrite;
  wire rd_en = access && !pwrite;
  wire hit_range = paddr == `RA_OFF_RANGE_CFG;
  wire hit_stat = paddr == `RA_OFF_ALARM_STAT;
  wire hit_upper = paddr == `RA_OFF_UPPER_LIM;
  wire hit_lower = paddr == `RA_OFF_LOWER_LIM;
  wire hit_mask = paddr == `RA_OFF_IRQ_MASK;
  wire hit_sup = paddr == `RA_OFF_SUPPLY_LIM;
  wire mapped = hit_range || hit_stat || hit_upper || hit_lower || hit_mask || hit_sup;
  // status is read-only, a write there is answered as an error
  wire bad_access = !mapped || (pwrite && hit_stat);

  // zero-wait slave: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  wire wr_range = wr_en && hit_range && pstrb[0];
  wire [15:0] upper_nxt = {pstrb[1] ? pwdata[15:8] : upper_lim_r[15:8],
                           pstrb[0] ? pwdata[7:0] : upper_lim_r[7:0]};
  wire [15:0] lower_nxt = {pstrb[1] ? pwdata[15:8] : lower_lim_r[15:8],
                           pstrb[0] ? pwdata[7:0] : lower_lim_r[7:0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      range_code_r <= `RA_RANGE_RST;
      ref_off_r <= `RA_REF_OFF_RST;
    end
    else if (wr_range)
    begin
      range_code_r <= pwdata[`RA_RANGE_MSB:`RA_RANGE_LSB];
      ref_off_r <= pwdata[`RA_REF_OFF_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upper_lim_r <= `RA_UPPER_LIM_RST;
      lower_lim_r <= `RA_LOWER_LIM_RST;
    end
    else
    begin
      if (wr_en && hit_upper)
        upper_lim_r <= upper_nxt;
      if (wr_en && hit_lower)
        lower_lim_r <= lower_nxt;
    end
  end

  // supply limits: low word lower limit, high word upper limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sup_lo_r <= SUPPLY_W'(`RA_SUP_LO_RST);
      sup_hi_r <= SUPPLY_W'(`RA_SUP_HI_RST);
      irq_mask_r <= `RA_MASK_RST;
    end
    else
    begin
      if (wr_en && hit_sup)
      begin
        sup_lo_r <= pwdata[SUPPLY_W-1:0];
        sup_hi_r <= pwdata[16+SUPPLY_W-1:16];
      end
      if (wr_en && hit_mask && pstrb[0])
        irq_mask_r <= pwdata[3:0];
    end
  end

  // ----------------------------------------
  // range decode
  // ----------------------------------------
  assign range_code = range_code_r;
  assign internal_reference_off = ref_off_r;
  assign range_unipolar = range_code_r[3];
  // a repeated printed code leaves seven codes with no defined span
  assign range_unassigned = !(range_code_r inside {
    range_alarm_pkg::bip_3_0, range_alarm_pkg::bip_2_5, range_alarm_pkg::bip_1_5,
    range_alarm_pkg::bip_1_25, range_alarm_pkg::bip_0_625, range_alarm_pkg::uni_3_0,
    range_alarm_pkg::uni_2_5, range_alarm_pkg::uni_1_5, range_alarm_pkg::uni_1_25});

  // ----------------------------------------
  // alarm comparison
  // ----------------------------------------
  wire [SAMPLE_W-1:0] upper_full = {upper_lim_r, `RA_LIM_PAD};
  wire [SAMPLE_W-1:0] lower_full = {lower_lim_r, `RA_LIM_PAD};
  logic in_above;
  logic in_below;
  logic sup_above;
  logic sup_below;

  limit_compare #(.W(SAMPLE_W)) u_in_cmp (
    .value(sample_code),
    .upper(upper_full),
    .lower(lower_full),
    .above(in_above),
    .below(in_below)
  );

  limit_compare #(.W(SUPPLY_W)) u_sup_cmp (
    .value(supply_code),
    .upper(sup_hi_r),
    .lower(sup_lo_r),
    .above(sup_above),
    .below(sup_below)
  );

  // live flags hold the last valid comparison
  range_alarm_pkg::alarm_set_t live_r;
  range_alarm_pkg::alarm_set_t live_nxt;
  range_alarm_pkg::alarm_set_t event_now;
  range_alarm_pkg::alarm_set_t latched;

  always_comb
  begin
    live_nxt = live_r;
    if (supply_valid)
    begin
      live_nxt.supply_low = sup_below;
      live_nxt.supply_high = sup_above;
    end
    if (sample_valid)
    begin
      live_nxt.input_lowside = in_below;
      live_nxt.input_highside = in_above;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      live_r <= '0;
    else
      live_r <= live_nxt;
  end

  // an event is a valid comparison that trips, not a standing live flag
  assign event_now = {supply_valid && sup_below, supply_valid && sup_above,
                      sample_valid && in_below, sample_valid && in_above};

  // a status read clears only what the host was shown at setup, so an
  // event landing on the setup edge is not lost; a coincident event survives
  wire stat_read = rd_en && hit_stat;
  wire [3:0] lat_seen = {prdata_r[`RA_LAT_SUP_LO_BIT], prdata_r[`RA_LAT_SUP_HI_BIT],
                         prdata_r[`RA_LAT_IN_LO_BIT], prdata_r[`RA_LAT_IN_HI_BIT]};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_latch
      latched_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(event_now[g]),
        .clr(stat_read && lat_seen[g]),
        .flag_r(latched[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // status word and read mux
  // ----------------------------------------
  logic [31:0] stat_word;

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`RA_LIVE_SUP_LO_BIT] = live_r.supply_low;
    stat_word[`RA_LIVE_SUP_HI_BIT] = live_r.supply_high;
    stat_word[`RA_LIVE_IN_LO_BIT] = live_r.input_lowside;
    stat_word[`RA_LIVE_IN_HI_BIT] = live_r.input_highside;
    stat_word[`RA_LAT_SUP_LO_BIT] = latched.supply_low;
    stat_word[`RA_LAT_SUP_HI_BIT] = latched.supply_high;
    stat_word[`RA_LAT_IN_LO_BIT] = latched.input_lowside;
    stat_word[`RA_LAT_IN_HI_BIT] = latched.input_highside;
    stat_word[`RA_SUMMARY_BIT] = |latched;
  end

  logic [31:0] range_word;

  always_comb
  begin
    range_word = 32'h0000_0000;
    range_word[`RA_RANGE_MSB:`RA_RANGE_LSB] = range_code_r;
    range_word[`RA_REF_OFF_BIT] = ref_off_r;
  end

  wire [31:0] rd_mux =
    hit_range ? range_word :
    hit_stat ? stat_word :
    hit_upper ? {16'h0000, upper_lim_r} :
    hit_lower ? {16'h0000, lower_lim_r} :
    hit_mask ? {28'h0000000, irq_mask_r} :
    hit_sup ? {16'(sup_hi_r), 16'(sup_lo_r)} :
    32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      // data registered in setup so it stands through the access cycle
      prdata_r <= (psel && !penable && !pwrite) ? rd_mux : prdata_r;
      pslverr_r <= psel && !penable && bad_access;
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  logic irq_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(latched & irq_mask_r);
  end

  assign alarm_irq = irq_r;
endmodule

/* dv/range_alarm_regs_properties.sv */
// port assertions for the range and alarm register bank
module range_alarm_regs_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // converter side
  input wire logic [3:0] range_code,
  input wire logic range_unassigned,
  input wire logic internal_reference_off
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rng_wr = acc && pwrite && paddr == 12'h014 && pstrb[0];
  wire rng_rd = acc && !pwrite && paddr == 12'h014;
  wire st_rd = acc && !pwrite && paddr == 12'h020;
  a_range_update: assert property (rng_wr |=> range_code == $past(pwdata[3:0]))
    else $error("range code not taken from write");
  a_ref_update: assert property (rng_wr |=> internal_reference_off == $past(pwdata[6]))
    else $error("reference control not taken from write");
  a_rd_range_zero: assert property (rng_rd |-> prdata[31:7] == 25'h0 && prdata[5:4] == 2'h0)
    else $error("range reserved bits not zero");
  a_rd_range_back: assert property (rng_rd |-> prdata[6:0] == {internal_reference_off, 2'h0, range_code})
    else $error("range readback differs from outputs");
  a_stat_reserved: assert property (st_rd |-> prdata[31:16] == 16'h0 && prdata[13:12] == 2'h0
    && prdata[9:8] == 2'h0 && prdata[3:1] == 3'h0)
    else $error("status reserved bits not zero");
  a_summary_or: assert property (st_rd |-> prdata[0] == |prdata[7:4])
    else $error("summary bit not or of latched flags");
  a_stat_write_err: assert property (acc && pwrite && paddr == 12'h020 |-> pslverr)
    else $error("status write not refused");
  a_unassigned_code: assert property (range_unassigned == !(range_code < 4'h5 || range_code[3:2] == 2'h2))
    else $error("unassigned flag wrong for code");
  a_ready_high: assert property (psel |-> pready)
    else $error("ready low during transfer");
endmodule

bind range_alarm_regs range_alarm_regs_properties i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .range_code(range_code),
  .range_unassigned(range_unassigned), .internal_reference_off(internal_reference_off));

/* dv/apb_host.sv */
// apb master standing in for the host controller
module apb_host (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] q_s;
  logic e_s;
  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // answer captured at the ready edge itself, avoiding a race with the slave
  always @(posedge pclk)
    if (psel && penable && pready)
    begin
      q_s <= prdata;
      e_s <= pslverr;
    end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    q = q_s;
    e = e_s;
  endtask
endmodule

/* dv/test_range_alarm_regs.sv */
// self-checking bench for the range and alarm register bank
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin num_errors++; \
  $display("FAIL %s exp %h got %h", n, x, g); end end
module test_range_alarm_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, range_unassigned, range_unipolar, e;
  logic internal_reference_off, alarm_irq, sample_valid = 1'b0, supply_valid = 1'b0;
  logic [11:0] paddr, v;
  logic [11:0] supply_code = 12'h0;
  logic [17:0] sample_code = 18'h0;
  logic [17:0] s;
  logic [31:0] pwdata, prdata, q, d;
  logic [3:0] pstrb, range_code;
  logic [11:0] ra [4] = '{12'h014, 12'h020, 12'h024, 12'h028};
  logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h0000FFFF, 32'h0};
  logic [17:0] sc [4] = '{18'h20000, 18'h20001, 18'h03FFF, 18'h04000};
  logic [11:0] vc [4] = '{12'hE00, 12'hE01, 12'h0FF, 12'h100};
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  range_alarm_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .sample_code(sample_code),
    .supply_valid(supply_valid), .supply_code(supply_code), .range_code(range_code),
    .range_unassigned(range_unassigned), .range_unipolar(range_unipolar),
    .internal_reference_off(internal_reference_off), .alarm_irq(alarm_irq));
  // -----------------------------------------
  // helpers
  // -----------------------------------------
  task automatic rd(input logic [11:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] x);
    i_host.xfer(1'b1, a, x, q, e);
  endtask
  task automatic pulse(input logic [17:0] a, input logic [11:0] b);
    sample_code <= a;
    supply_code <= b;
    {sample_valid, supply_valid} <= 2'h3;
    @(posedge pclk);
    {sample_valid, supply_valid} <= 2'h0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] exp_stat(logic [17:0] a, logic [11:0] b);
    logic [3:0] f;
    f = {b < 12'h100, b > 12'hE00, a < {16'h1000, 2'h0}, a > {16'h8000, 2'h0}};
    return {16'h0, f[3:2], 2'h0, f[1:0], 2'h0, f, 3'h0, |f};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      test_done();
    end
  end
  // -----------------------------------------
  // tests
  // -----------------------------------------
  initial
  begin
    void'($urandom(32'h4AD5DC33));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i])
    begin
      rd(ra[i]);
      `CHK("reset value", rv[i], q)
    end
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      d = $urandom;
      d[3:0] = i[3:0];
      wr(12'h014, d);
      rd(12'h014);
      `CHK("range reg", d & 32'h0000004F, q)
      `CHK("range code", d[3:0], range_code)
      `CHK("unipolar", d[3], range_unipolar)
      `CHK("unassigned", !(d[3:0] < 4'h5 || d[3:2] == 2'h2), range_unassigned)
      `CHK("ref off", d[6], internal_reference_off)
    end
    $display("test range done");
    rd(12'h040);
    `CHK("unmapped err", 1'b1, e)
    wr(12'h020, 32'hFFFFFFFF);
    `CHK("status write err", 1'b1, e)
    rd(12'h020);
    `CHK("status untouched", 32'h0, q)
    $display("test refuse done");
    wr(12'h024, 32'h00008000);
    wr(12'h028, 32'h00001000);
    wr(12'h034, 32'h0E000100);
    for (int i = 0; i < 20; i++)
    begin
      s = (i < 4) ? sc[i] : 18'($urandom);
      v = (i < 4) ? vc[i] : 12'($urandom);
      pulse(s, v);
      rd(12'h020);
      `CHK("status", exp_stat(s, v), q)
      rd(12'h020);
      `CHK("after clear", exp_stat(s, v) & 32'h0000CC00, q)
    end
    $display("test alarm done");
    wr(12'h030, 32'h0);
    pulse(18'h3FFFF, 12'h800);
    repeat (2) @(posedge pclk);
    `CHK("irq masked", 1'b0, alarm_irq)
    wr(12'h030, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq raised", 1'b1, alarm_irq)
    pulse(18'h10000, 12'h800);
    rd(12'h020);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'b0, alarm_irq)
    $display("test irq done");
    test_done();
  end
endmodule
